// [rtl/access_gate_pkg.sv]
// Constants shared by the access-mode gate and its key store.
// Assumes a byte-addressed Avalon-MM slave port with 32-bit data.
package access_gate_pkg;

    // ========================================================
    // Register map (byte addresses)
    localparam logic [7:0] CTRL_CMD_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] OPEN_KEY0_OFS = 8'h08;
    localparam logic [7:0] OPEN_KEY1_OFS = 8'h0c;
    localparam logic [7:0] PRIV_KEY0_OFS = 8'h10;
    localparam logic [7:0] PRIV_KEY1_OFS = 8'h14;
    localparam logic [7:0] LOCK_CMD_OFS = 8'h18;
    // Word index sits above the two byte-lane address bits.
    localparam int KEY_WORD_LSB = 2;

    // ========================================================
    // Status word fields and lock command bit
    localparam int LOCKED_FLAG_BIT = 0;
    localparam int PRIV_FLAG_BIT = 1;
    localparam int LEVEL_LSB = 2;
    localparam int PAIR_PEND_BIT = 4;
    localparam int LOCK_REQ_BIT = 0;

    // ========================================================
    // Key store layout and reset contents
    localparam int KEY_W = 16;
    localparam int KEY_WORDS = 4;
    localparam int KEY_AW = 2;
    localparam logic [KEY_AW-1:0] OPEN_KEY_BASE = 2'h0;
    localparam logic [KEY_AW-1:0] PRIV_KEY_BASE = 2'h2;
    localparam logic [KEY_W-1:0] OPEN_KEY0_RST = 16'h3672;
    localparam logic [KEY_W-1:0] OPEN_KEY1_RST = 16'h0414;
    localparam logic [KEY_W-1:0] PRIV_KEY0_RST = 16'hffff;
    localparam logic [KEY_W-1:0] PRIV_KEY1_RST = 16'hffff;

    // ========================================================
    // Protection levels and controller states
    typedef enum logic [1:0] {
        LOCKED_LEVEL = 2'b00,
        OPEN_LEVEL = 2'b01,
        PRIV_LEVEL = 2'b10
    } level_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CHK0 = 3'b001,
        ST_CHK1 = 3'b010,
        ST_RD1 = 3'b011,
        ST_RD2 = 3'b100
    } state_t;

endpackage

// [rtl/key_store.sv]
// Four-word non-volatile key store model with registered read data.
// Assumes one write and one read port on the same clock.
`timescale 1ns/1ps
`default_nettype none
module key_store (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Write port
    input wire logic we,
    input wire logic [access_gate_pkg::KEY_AW-1:0] waddr,
    input wire logic [access_gate_pkg::KEY_W-1:0] wdata,
    // Read port
    input wire logic [access_gate_pkg::KEY_AW-1:0] raddr,
    output logic [access_gate_pkg::KEY_W-1:0] rdata
);
    import access_gate_pkg::*;

    logic [KEY_W-1:0] mem_reg [KEY_WORDS];

    // Keys live apart from the working registers; reset loads the default open keys and all-ones privileged keys.
    // ========================================================
    // Storage
    // two-byte key words.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_reg[0] <= OPEN_KEY0_RST;
            mem_reg[1] <= OPEN_KEY1_RST;
            mem_reg[2] <= PRIV_KEY0_RST;
            mem_reg[3] <= PRIV_KEY1_RST;
        end else if (we) begin
            mem_reg[waddr] <= wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= mem_reg[raddr];
        end
    end
endmodule // key_store
`default_nettype wire

// [rtl/access_gate.sv]
// Protection-level controller for the parameter store.
// Assumes an Avalon-MM master with waitrequest and a parameter store
// that asks for permission on the acc_* lines before each access.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - three levels decide parameter access.
// - locked allows public reads and public mfg-block writes outside block A.
// - only privileged level may change keys.
// - matching key pair changes level.
// - locked flag set, cleared by open key.
// - privileged flag cleared by privileged key.
// - keys are two-byte words in store.
// - key writes refused unless privileged.
// - locked level blocks block A commit.
// - class select unavailable while locked.
module access_gate (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Parameter store permission check
    input wire logic acc_private,
    input wire logic acc_write,
    input wire logic acc_mfg_block,
    input wire logic acc_block_a,
    output logic acc_grant,
    output logic class_select_enable,
    // Level state
    output logic locked_level,
    output logic open_level,
    output logic privileged_state_flag
);
    import access_gate_pkg::*;

    function automatic logic [KEY_W-1:0] bswap16(input logic [KEY_W-1:0] w);
        bswap16 = {w[7:0], w[15:8]};
    endfunction

    function automatic logic is_key_ofs(input logic [7:0] a);
        is_key_ofs = (a == OPEN_KEY0_OFS) || (a == OPEN_KEY1_OFS) ||
            (a == PRIV_KEY0_OFS) || (a == PRIV_KEY1_OFS);
    endfunction

    function automatic logic [KEY_AW-1:0] key_index(input logic [7:0] a);
        key_index = a[KEY_WORD_LSB +: KEY_AW] - OPEN_KEY0_OFS[KEY_WORD_LSB +: KEY_AW];
    endfunction

    state_t state_reg;
    level_t level_reg;
    logic priv_flag_reg;
    logic [KEY_W-1:0] last_word_reg;
    logic last_valid_reg;
    logic [KEY_W-1:0] pair_w1_reg;
    logic [KEY_W-1:0] pair_w2_reg;
    logic match0_reg;
    logic [31:0] readdata_reg;
    logic [KEY_AW-1:0] key_base;
    logic [KEY_AW-1:0] mem_raddr;
    logic [KEY_W-1:0] mem_rdata;
    logic mem_we;
    logic half_ok;
    logic ctrl_wr;
    logic start_check;
    logic pair_hit;
    logic [31:0] status_word;

    // ========================================================
    // Bus decode
    // Low half-word must be written whole: a key split across two bus writes could tear.
    assign half_ok = (byteenable[1:0] == 2'b11);
    assign ctrl_wr = (state_reg == ST_IDLE) && write && (address == CTRL_CMD_OFS) && half_ok;
    // pair checked on every second control word below privileged level.
    assign start_check = ctrl_wr && last_valid_reg && (level_reg != PRIV_LEVEL);
    assign key_base = (level_reg == LOCKED_LEVEL) ? OPEN_KEY_BASE : PRIV_KEY_BASE;
    assign pair_hit = match0_reg && (bswap16(pair_w2_reg) == mem_rdata);
    // Stalling other requests during a check keeps the pair order intact.
    assign waitrequest = !(((state_reg == ST_IDLE) && write) || (state_reg == ST_RD2));
    assign readdata = readdata_reg;

    always_comb begin
        mem_raddr = key_base;
        if (state_reg == ST_IDLE && read) begin
            mem_raddr = key_index(address);
        end else if (state_reg == ST_CHK0) begin
            mem_raddr = key_base + 2'h1;
        end
    end

    assign mem_we = (state_reg == ST_IDLE) && write && is_key_ofs(address) && half_ok &&
        (level_reg == PRIV_LEVEL);

    key_store u_keys (
        .mclk(mclk),
        .rst_n(rst_n),
        .we(mem_we),
        .waddr(key_index(address)),
        .wdata(writedata[KEY_W-1:0]),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // ========================================================
    // Controller sequence
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (start_check) begin
                        state_reg <= ST_CHK0;
                    end else if (read) begin
                        state_reg <= ST_RD1;
                    end
                end
                ST_CHK0: state_reg <= ST_CHK1;
                ST_CHK1: state_reg <= ST_IDLE;
                ST_RD1: state_reg <= ST_RD2;
                ST_RD2: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ========================================================
    // Key word tracking
    // control words pair two by two, even with other transfers between them.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            last_word_reg <= '0;
            last_valid_reg <= 1'b0;
            pair_w1_reg <= '0;
            pair_w2_reg <= '0;
        end else if (ctrl_wr) begin
            last_word_reg <= writedata[KEY_W-1:0];
            last_valid_reg <= !start_check;
            pair_w1_reg <= last_word_reg;
            pair_w2_reg <= writedata[KEY_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            match0_reg <= 1'b0;
        end else if (state_reg == ST_CHK0) begin
            match0_reg <= (bswap16(pair_w1_reg) == mem_rdata);
        end
    end

    // ========================================================
    // Level and flags
    // mismatch leaves level alone.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            level_reg <= LOCKED_LEVEL;
        end else if ((state_reg == ST_IDLE) && write && (address == LOCK_CMD_OFS) &&
                byteenable[0] && writedata[LOCK_REQ_BIT]) begin
            level_reg <= LOCKED_LEVEL;
        end else if ((state_reg == ST_CHK1) && pair_hit) begin
            level_reg <= (level_reg == LOCKED_LEVEL) ? OPEN_LEVEL : PRIV_LEVEL;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            priv_flag_reg <= 1'b1;
        end else if ((state_reg == ST_CHK1) && pair_hit && (level_reg == OPEN_LEVEL)) begin
            priv_flag_reg <= 1'b0;
        end else if (level_reg != PRIV_LEVEL) begin
            priv_flag_reg <= 1'b1;
        end
    end

    assign locked_level = (level_reg == LOCKED_LEVEL);
    assign open_level = (level_reg == OPEN_LEVEL);
    assign privileged_state_flag = priv_flag_reg;

    // ========================================================
    // Read path
    always_comb begin
        status_word = '0;
        status_word[LOCKED_FLAG_BIT] = locked_level;
        status_word[PRIV_FLAG_BIT] = priv_flag_reg;
        status_word[LEVEL_LSB +: 2] = level_reg;
        status_word[PAIR_PEND_BIT] = last_valid_reg;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            readdata_reg <= '0;
        end else if (state_reg == ST_RD1) begin
            readdata_reg <= '0;
            if (address == STATUS_OFS) begin
                readdata_reg <= status_word;
            end else if (is_key_ofs(address) && !locked_level) begin
                // Keys are private, so locked level reads them as zero.
                readdata_reg <= {16'h0000, mem_rdata};
            end
        end
    end

    // ========================================================
    // Parameter store permission
    // level selects access.
    always_comb begin
        if (level_reg == LOCKED_LEVEL) begin
            acc_grant = !acc_private && (!acc_write || (acc_mfg_block && !acc_block_a));
        end else begin
            acc_grant = 1'b1;
        end
    end

    assign class_select_enable = (level_reg != LOCKED_LEVEL);

endmodule // access_gate
`default_nettype wire

// [tb/access_gate_assertions.sv]
// Port checker for the access gate.
// Assumes binding to every access_gate instance.
`timescale 1ns/1ps
`default_nettype none
module access_gate_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Bus and permission lines
    input wire logic waitrequest,
    input wire logic acc_private,
    input wire logic acc_write,
    input wire logic acc_mfg_block,
    input wire logic acc_block_a,
    input wire logic acc_grant,
    input wire logic class_select_enable,
    // Level state
    input wire logic locked_level,
    input wire logic open_level,
    input wire logic privileged_state_flag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Assertions
    private_lock_a: assert property (locked_level && acc_private |-> !acc_grant)
        else $error("private access granted while locked");
    public_read_a: assert property (locked_level && !acc_private && !acc_write |-> acc_grant)
        else $error("public read refused while locked");
    block_a_a: assert property (locked_level && acc_write && acc_block_a |-> !acc_grant)
        else $error("block A write granted while locked");
    open_grant_a: assert property (!locked_level |-> acc_grant)
        else $error("access refused outside locked level");
    class_sel_a: assert property (class_select_enable == !locked_level)
        else $error("class select enable wrong");
    one_level_a: assert property (!(locked_level && open_level))
        else $error("two levels at once");
    unlock_stall_a: assert property ($fell(locked_level) |-> $past(waitrequest, 2))
        else $error("unlock without key check stall");
    unlock_open_a: assert property ($fell(locked_level) |-> open_level)
        else $error("locked flag cleared without open level");
    priv_open_a: assert property ($fell(privileged_state_flag) |-> $past(open_level))
        else $error("privileged flag cleared outside open level");
    cover property ($fell(locked_level));
    cover property ($fell(privileged_state_flag));
    cover property (locked_level && acc_write && acc_mfg_block && acc_grant);
endmodule // access_gate_checker
bind access_gate access_gate_checker chk_u (.mclk(mclk), .rst_n(rst_n),
    .waitrequest(waitrequest), .acc_private(acc_private), .acc_write(acc_write),
    .acc_mfg_block(acc_mfg_block), .acc_block_a(acc_block_a), .acc_grant(acc_grant),
    .class_select_enable(class_select_enable), .locked_level(locked_level),
    .open_level(open_level), .privileged_state_flag(privileged_state_flag));
`default_nettype wire

// [tb/host_model.sv]
// Host controller model: Avalon-MM master issuing transfers and key pairs.
// Assumes a slave on the same clock that answers with waitrequest.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input wire logic mclk,
    // Avalon-MM master
    output logic [7:0] address,
    output logic read,
    output logic write,
    output logic [3:0] byteenable,
    output logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Wait limit used up
    output logic hang
);
    import access_gate_pkg::*;
    initial begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        byteenable = 4'hf;
        writedata = 32'h0;
        hang = 1'b0;
    end
    // ==========================================
    // Transfers
    // Single words only, never block writes.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        q = '0;
        @(posedge mclk);
        address <= a;
        write <= w;
        read <= !w;
        byteenable <= be;
        writedata <= d;
        // The request stands until an edge finds waitrequest low; that edge ends it.
        while (!done && n < 60) begin
            @(posedge mclk);
            n++;
            if (waitrequest === 1'b0) begin
                done = 1'b1;
                q = readdata;
            end
        end
        if (!done) begin
            hang <= 1'b1;
        end
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic send_pair(input logic [15:0] k0, input logic [15:0] k1);
        logic [31:0] q;
        xfer(1'b1, CTRL_CMD_OFS, {16'h0, k0[7:0], k0[15:8]}, 4'hf, q);
        xfer(1'b1, CTRL_CMD_OFS, {16'h0, k1[7:0], k1[15:8]}, 4'hf, q);
    endtask
endmodule // host_model
`default_nettype wire

// [tb/tb.sv]
// Testbench for the access gate, driven through the host model.
// Assumes the gate package and the key store are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import access_gate_pkg::*;
    logic mclk, rst_n, read, write, waitrequest, hang, acc_grant, class_select_enable;
    logic acc_private, acc_write, acc_mfg_block, acc_block_a;
    logic locked_level, open_level, privileged_state_flag;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, q;
    int num_errors, total_checks;
    always #4 mclk = ~mclk;
    host_model host_u (.mclk(mclk), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .hang(hang));
    access_gate dut_u (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .acc_private(acc_private),
        .acc_write(acc_write), .acc_mfg_block(acc_mfg_block), .acc_block_a(acc_block_a),
        .acc_grant(acc_grant), .class_select_enable(class_select_enable),
        .locked_level(locked_level), .open_level(open_level),
        .privileged_state_flag(privileged_state_flag));
    // ==========================================
    // Checking tasks
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        host_u.xfer(1'b0, a, 32'h0, 4'hf, q);
        chk32(q, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, 4'hf, q);
    endtask
    // Locked grants public reads and public mfg-block writes outside block A only.
    task automatic perm(input logic lk);
        logic [3:0] c;
        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            @(posedge mclk);
            {acc_private, acc_write, acc_mfg_block, acc_block_a} <= c;
            @(negedge mclk);
            chk1(acc_grant, !lk || (!c[3] && (!c[2] || (c[1] && !c[0]))));
            chk1(class_select_enable, !lk);
        end
    endtask
    always @(posedge mclk) begin
        if (hang === 1'b1) begin
            num_errors++;
            conclude();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        {acc_private, acc_write, acc_mfg_block, acc_block_a} = 4'h0;
        num_errors = 0;
        total_checks = 0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rd(STATUS_OFS, 32'h3);
        chk1(locked_level, 1'b1);
        chk1(privileged_state_flag, 1'b1);
        rd(8'h1c, 32'h0);
        rd(OPEN_KEY0_OFS, 32'h0);
        perm(1'b1);
        $display("test locked done");
        host_u.send_pair(16'h1111, 16'h2222);
        rd(STATUS_OFS, 32'h3);
        wr(CTRL_CMD_OFS, 32'h7236);
        wr(CTRL_CMD_OFS, 32'h5a5a);
        wr(CTRL_CMD_OFS, 32'h1404);
        rd(STATUS_OFS, 32'h13);
        wr(CTRL_CMD_OFS, 32'h5a5a);
        rd(STATUS_OFS, 32'h3);
        host_u.xfer(1'b1, CTRL_CMD_OFS, 32'h7236, 4'hc, q);
        rd(STATUS_OFS, 32'h3);
        $display("test bad pairs done");
        host_u.send_pair(OPEN_KEY0_RST, OPEN_KEY1_RST);
        rd(STATUS_OFS, 32'h6);
        chk1(locked_level, 1'b0);
        chk1(open_level, 1'b1);
        wr(OPEN_KEY0_OFS, 32'h1234);
        rd(OPEN_KEY0_OFS, {16'h0, OPEN_KEY0_RST});
        perm(1'b0);
        $display("test open done");
        host_u.send_pair(PRIV_KEY0_RST, PRIV_KEY1_RST);
        rd(STATUS_OFS, 32'h8);
        chk1(privileged_state_flag, 1'b0);
        chk1(open_level, 1'b0);
        wr(OPEN_KEY0_OFS, 32'h1234);
        rd(OPEN_KEY0_OFS, 32'h1234);
        wr(LOCK_CMD_OFS, 32'h1);
        rd(STATUS_OFS, 32'h3);
        chk1(locked_level, 1'b1);
        chk1(privileged_state_flag, 1'b1);
        host_u.send_pair(16'h1234, OPEN_KEY1_RST);
        rd(STATUS_OFS, 32'h6);
        $display("test privileged done");
        conclude();
    end
endmodule // tb
`default_nettype wire
